/* File: asf_unit.v */
/*
 accumulator shift and flag set unit: executes set-bit and the three
 single-bit shift instructions, and exposes state on a plain register port.
 assumes one opcode strobe per cycle from the core decode, same clock.
*/
`timescale 1ns/1ps
`include "asf_map.vh"

// Notes on behaviour
// - set-bit forces chosen bit, others untouched
// - eight selectable status and control bits
// - test condition is status word one bit 11
// - left shift: bit31 to carry, zero in
// - sign extension never affects left shifts
// - paired left shift treats 64-bit concatenation
// - extension bit31 into accumulator bit0
// - sign extension set: arithmetic right shift
// - sign extension clear: logical right shift
// - right shift loads carry with old bit0
// - each recognised instruction advances program counter by one; unknown opcodes leave it
module asf_unit
#(
    parameter DATA_W = 32
)
(
    input wire mclk,
    input wire reset,
    input wire opValid,
    input wire [15:0] opWord,
    input wire [2:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdata,
    output reg [DATA_W-1:0] accOut,
    output reg [DATA_W-1:0] extOut,
    output reg carryOut,
    output reg xfPinOut,
    output reg opDone,
    output reg opUnknown
);
    reg [15:0] st0_reg;
    reg [15:0] st0_next;
    reg [15:0] st1_reg;
    reg [15:0] st1_next;
    reg [DATA_W-1:0] acc_reg;
    reg [DATA_W-1:0] acc_next;
    reg [DATA_W-1:0] ext_reg;
    reg [DATA_W-1:0] ext_next;
    reg [15:0] pc_reg;
    reg [15:0] cnt_reg;
    reg [15:0] rd_next;
    wire setOp;
    wire shlOp;
    wire pairShlOp;
    wire shrOp;
    wire known;
    wire [7:0] bitSel;
    wire signMode;
    wire exec;

    asf_decode u_dec
    (
        .opWord(opWord),
        .setOp(setOp),
        .shlOp(shlOp),
        .pairShlOp(pairShlOp),
        .shrOp(shrOp),
        .bitSel(bitSel),
        .known(known)
    );

    assign signMode = st1_reg[`ASF_ST1_SXM];
    assign exec = opValid & known;

    // instruction execution; register writes land first so an instruction
    // in the same cycle sees old state and overrides its own bits
    always @*
    begin
        st0_next = st0_reg;
        st1_next = st1_reg;
        acc_next = acc_reg;
        ext_next = ext_reg;
        if (regWr)
        begin
            case (regAddr)
                `ASF_REG_ST0: st0_next = regWdata;
                `ASF_REG_ST1: st1_next = regWdata;
                `ASF_REG_ACCLO: acc_next[15:0] = regWdata;
                `ASF_REG_ACCHI: acc_next[DATA_W-1:16] = regWdata[DATA_W-17:0];
                `ASF_REG_EXTLO: ext_next[15:0] = regWdata;
                `ASF_REG_EXTHI: ext_next[DATA_W-1:16] = regWdata[DATA_W-17:0];
                default: st0_next = st0_next;
            endcase
        end
        if (opValid && setOp)
        begin
            if (bitSel[0]) st1_next[`ASF_ST1_C] = 1'b1;
            if (bitSel[1]) st1_next[`ASF_ST1_CNF] = 1'b1;
            if (bitSel[2]) st1_next[`ASF_ST1_HM] = 1'b1;
            if (bitSel[3]) st0_next[`ASF_ST0_GLOBAL_INTERRUPT_MASK] = 1'b1;
            if (bitSel[4]) st0_next[`ASF_ST0_OVM] = 1'b1;
            if (bitSel[5]) st1_next[`ASF_ST1_SXM] = 1'b1;
            if (bitSel[6]) st1_next[`ASF_ST1_TC] = 1'b1;
            if (bitSel[7]) st1_next[`ASF_ST1_XF] = 1'b1;
        end
        if (opValid && shlOp)
        begin
            // sign mode deliberately not read on left shifts
            st1_next[`ASF_ST1_C] = acc_reg[DATA_W-1];
            acc_next = {acc_reg[DATA_W-2:0], 1'b0};
        end
        if (opValid && pairShlOp)
        begin
            st1_next[`ASF_ST1_C] = acc_reg[DATA_W-1];
            {acc_next, ext_next} = {acc_reg[DATA_W-2:0], ext_reg, 1'b0};
        end
        if (opValid && shrOp)
        begin
            st1_next[`ASF_ST1_C] = acc_reg[0];
            if (signMode)
                acc_next = {acc_reg[DATA_W-1], acc_reg[DATA_W-1:1]};
            else
                acc_next = {1'b0, acc_reg[DATA_W-1:1]};
        end
    end

    always @*
    begin
        case (regAddr)
            `ASF_REG_ST0: rd_next = st0_reg;
            `ASF_REG_ST1: rd_next = st1_reg;
            `ASF_REG_ACCLO: rd_next = acc_reg[15:0];
            `ASF_REG_ACCHI: rd_next = acc_reg[DATA_W-1:16];
            `ASF_REG_EXTLO: rd_next = ext_reg[15:0];
            `ASF_REG_EXTHI: rd_next = ext_reg[DATA_W-1:16];
            `ASF_REG_PC: rd_next = pc_reg;
            `ASF_REG_CNT: rd_next = cnt_reg;
            default: rd_next = 16'h0000;
        endcase
    end

    always @(posedge mclk)
    begin
        if (reset)
        begin
            st0_reg <= `ASF_ST0_RST;
            st1_reg <= `ASF_ST1_RST;
            acc_reg <= `ASF_ACC_RST;
            ext_reg <= `ASF_ACC_RST;
            pc_reg <= `ASF_PC_RST;
            cnt_reg <= 16'h0000;
            regRdata <= 16'h0000;
            accOut <= `ASF_ACC_RST;
            extOut <= `ASF_ACC_RST;
            carryOut <= 1'b0;
            xfPinOut <= 1'b0;
            opDone <= 1'b0;
            opUnknown <= 1'b0;
        end
        else
        begin
            st0_reg <= st0_next;
            st1_reg <= st1_next;
            acc_reg <= acc_next;
            ext_reg <= ext_next;
            // one program word each, so pc steps by one
            if (exec)
                pc_reg <= pc_reg + `ASF_PC_STEP;
            else if (regWr && regAddr == `ASF_REG_PC)
                pc_reg <= regWdata;
            // count wraps; software reads it only as a progress hint
            if (exec)
                cnt_reg <= cnt_reg + 16'h0001;
            else if (regWr && regAddr == `ASF_REG_CNT)
                cnt_reg <= 16'h0000;
            regRdata <= regRd ? rd_next : 16'h0000;
            accOut <= acc_next;
            extOut <= ext_next;
            carryOut <= st1_next[`ASF_ST1_C];
            xfPinOut <= st1_next[`ASF_ST1_XF];
            opDone <= exec;
            opUnknown <= opValid & ~known;
        end
    end
endmodule // asf_unit

/* File: asf_map.vh */
/*
 header of constants for the accumulator shift and flag set unit:
 opcodes, status bit positions, reset values, register offsets.
 assumes it is included by bare name by the design files.
*/
`ifndef ASF_MAP_VH
`define ASF_MAP_VH

`define ASF_INSTR_W 16
`define ASF_OP_SET_CONTROL_BIT_OP_HI 10'h2f9
`define ASF_OP_HI_MSB 15
`define ASF_OP_HI_LSB 6
`define ASF_OP_SEL_MSB 5
`define ASF_OP_SFL 16'hbe09
`define ASF_OP_PAIRED_SHIFT_LEFT_OP 16'hbe16
`define ASF_OP_SFR 16'hbe0a

`define ASF_SEL_OVM 6'h02
`define ASF_SEL_SXM 6'h07
`define ASF_SEL_HM 6'h09
`define ASF_SEL_TC 6'h0b
`define ASF_SEL_C 6'h0f
`define ASF_SEL_XF 6'h0d
`define ASF_SEL_CNF 6'h05
`define ASF_SEL_GLOBAL_INTERRUPT_MASK 6'h01

`define ASF_ST0_OVM 11
`define ASF_ST0_GLOBAL_INTERRUPT_MASK 9
`define ASF_ST1_TC 11
`define ASF_ST1_SXM 10
`define ASF_ST1_C 9
`define ASF_ST1_CNF 12
`define ASF_ST1_HM 6
`define ASF_ST1_XF 4

`define ASF_ST0_RST 16'h0600
`define ASF_ST1_RST 16'h07f0
`define ASF_ACC_RST 32'h00000000
`define ASF_PC_RST 16'h0000
`define ASF_PC_STEP 16'h0001

`define ASF_ADDR_W 3
`define ASF_REG_ST0 3'h0
`define ASF_REG_ST1 3'h1
`define ASF_REG_ACCLO 3'h2
`define ASF_REG_ACCHI 3'h3
`define ASF_REG_EXTLO 3'h4
`define ASF_REG_EXTHI 3'h5
`define ASF_REG_PC 3'h6
`define ASF_REG_CNT 3'h7

`endif

/* File: asf_decode.v */
/*
 instruction decoder: turns one opcode word into one-hot operation strobes
 and a one-hot status bit selection.
 assumes the opcode comes from logic on the same clock.
*/
`timescale 1ns/1ps
`include "asf_map.vh"

module asf_decode
(
    input wire [15:0] opWord,
    output reg setOp,
    output reg shlOp,
    output reg pairShlOp,
    output reg shrOp,
    output reg [7:0] bitSel,
    output reg known
);
    always @*
    begin
        setOp = (opWord[`ASF_OP_HI_MSB:`ASF_OP_HI_LSB] == `ASF_OP_SET_CONTROL_BIT_OP_HI);
        shlOp = (opWord == `ASF_OP_SFL);
        pairShlOp = (opWord == `ASF_OP_PAIRED_SHIFT_LEFT_OP);
        shrOp = (opWord == `ASF_OP_SFR);
        bitSel = 8'h00;
        if (setOp)
        begin
            case (opWord[`ASF_OP_SEL_MSB:0])
                `ASF_SEL_C: bitSel = 8'h01;
                `ASF_SEL_CNF: bitSel = 8'h02;
                `ASF_SEL_HM: bitSel = 8'h04;
                `ASF_SEL_GLOBAL_INTERRUPT_MASK: bitSel = 8'h08;
                `ASF_SEL_OVM: bitSel = 8'h10;
                `ASF_SEL_SXM: bitSel = 8'h20;
                `ASF_SEL_TC: bitSel = 8'h40;
                `ASF_SEL_XF: bitSel = 8'h80;
                default: bitSel = 8'h00;
            endcase
        end
        // an unknown low field is ignored, not a trap
        if (setOp && bitSel == 8'h00)
        begin
            setOp = 1'b0;
        end
        known = setOp | shlOp | pairShlOp | shrOp;
    end
endmodule // asf_decode

/* File: asf_unit_chk.sv */
/* port checker for asf_unit: shift, set-bit and done relations.
 assumes a bind onto asf_unit and one clock domain. */
`timescale 1ns/1ps
`include "asf_map.vh"
module asf_unit_chk
#(
    parameter DATA_W = 32
)
(
    input wire mclk,
    input wire reset,
    input wire opValid,
    input wire [15:0] opWord,
    input wire regWr,
    input wire [DATA_W-1:0] accOut,
    input wire [DATA_W-1:0] extOut,
    input wire carryOut,
    input wire xfPinOut,
    input wire opDone,
    input wire opUnknown
);
    // a same-cycle write would change accOut under the $stable checks
    wire go = opValid && !regWr;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_shl_result:
    assert property (go && opWord == `ASF_OP_SFL |=> accOut == {$past(accOut[30:0]), 1'h0}
        && carryOut == $past(accOut[31])) else $error("left shift wrong");
    a_pair_shift:
    assert property (go && opWord == `ASF_OP_PAIRED_SHIFT_LEFT_OP |=> {carryOut, accOut, extOut}
        == {$past(accOut), $past(extOut), 1'h0}) else $error("paired shift wrong");
    a_shr_carry:
    assert property (go && opWord == `ASF_OP_SFR |=> carryOut == $past(accOut[0])) else $error("right carry wrong");
    a_shr_body:
    assert property (go && opWord == `ASF_OP_SFR |=> accOut[30:0] == $past(accOut[31:1])) else $error("right shift wrong");
    a_set_carry:
    assert property (go && opWord == {`ASF_OP_SET_CONTROL_BIT_OP_HI, `ASF_SEL_C} |=> carryOut && $stable(accOut)
        && $stable(extOut)) else $error("set carry wrong");
    a_set_flag:
    assert property (go && opWord == {`ASF_OP_SET_CONTROL_BIT_OP_HI, `ASF_SEL_XF} |=> xfPinOut) else $error("set flag pin wrong");
    a_op_done:
    assert property (go && opWord inside {`ASF_OP_SFL, `ASF_OP_PAIRED_SHIFT_LEFT_OP, `ASF_OP_SFR} |=> opDone && !opUnknown)
        else $error("done pulse wrong");
    a_bad_select:
    assert property (go && opWord == {`ASF_OP_SET_CONTROL_BIT_OP_HI, 6'h3f} |=> opUnknown && !opDone && $stable(accOut))
        else $error("bad select took effect");
endmodule // asf_unit_chk

bind asf_unit asf_unit_chk #(.DATA_W(DATA_W)) chk (.mclk(mclk), .reset(reset), .opValid(opValid),
    .opWord(opWord), .regWr(regWr), .accOut(accOut), .extOut(extOut), .carryOut(carryOut),
    .xfPinOut(xfPinOut), .opDone(opDone), .opUnknown(opUnknown));

/* File: test_asf_unit.sv */
/* self-checking bench for asf_unit over its instruction and register ports.
 assumes the port checker is bound from its own file. */
`timescale 1ns/1ps
`include "asf_map.vh"
module test_asf_unit;
    logic mclk = 0, reset = 1, opValid = 0, regWr = 0, regRd = 0, rdLate = 0;
    logic [15:0] opWord = 0, regWdata = 0, m [7], q [$];
    logic [15:0] ops [3] = '{`ASF_OP_SFL, `ASF_OP_PAIRED_SHIFT_LEFT_OP, `ASF_OP_SFR};
    logic [5:0] sels [9] = '{`ASF_SEL_OVM, `ASF_SEL_SXM, `ASF_SEL_HM, `ASF_SEL_TC, `ASF_SEL_C,
        `ASF_SEL_XF, `ASF_SEL_CNF, `ASF_SEL_GLOBAL_INTERRUPT_MASK, 6'h3f};
    logic [2:0] regAddr = 0;
    wire [15:0] regRdata;
    int error_cnt = 0, tests_run = 0;
    asf_unit dut (.mclk(mclk), .reset(reset), .opValid(opValid), .opWord(opWord), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .accOut(), .extOut(),
        .carryOut(), .xfPinOut(), .opDone(), .opUnknown());
    initial
        forever #2 mclk = ~mclk;
    initial
    begin
        #20000;
        error_cnt++;
        summarize();
    end
    // one flop of delay matches the read latency
    always @(posedge mclk)
    begin
        if (rdLate)
        begin
            tests_run++;
            if (regRdata !== q[0])
            begin
                error_cnt++;
                $display("wrong value regRdata expected %h seen %h", q[0], regRdata);
            end
            void'(q.pop_front());
        end
        rdLate <= regRd;
    end
    task summarize();
        if (error_cnt == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task go(input logic o, w, r, input logic [2:0] a, input logic [15:0] d);
        opValid <= o;
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= d;
        opWord <= d;
        @(posedge mclk);
    endtask
    task wr(input logic [2:0] a, input logic [15:0] d);
        go(0, 1, 0, a, d);
        m[a] = d;
    endtask
    task rd(input logic [2:0] a);
        q.push_back(m[a]);
        go(0, 0, 1, a, 0);
    endtask
    task op(input logic [15:0] w);
        go(1, 0, 0, 0, w);
        if (w == `ASF_OP_SFL)
            {m[1][9], m[3], m[2]} = {m[3], m[2], 1'h0};
        else if (w == `ASF_OP_PAIRED_SHIFT_LEFT_OP)
            {m[1][9], m[3], m[2], m[5], m[4]} = {m[3], m[2], m[5], m[4], 1'h0};
        else if (w == `ASF_OP_SFR)
            {m[3], m[2], m[1][9]} = {m[1][10] & m[3][15], m[3], m[2]};
        else if (w[15:6] == `ASF_OP_SET_CONTROL_BIT_OP_HI)
            case (w[5:0])
                `ASF_SEL_OVM: m[0][`ASF_ST0_OVM] = 1'h1;
                `ASF_SEL_GLOBAL_INTERRUPT_MASK: m[0][`ASF_ST0_GLOBAL_INTERRUPT_MASK] = 1'h1;
                `ASF_SEL_TC: m[1][`ASF_ST1_TC] = 1'h1;
                `ASF_SEL_SXM: m[1][`ASF_ST1_SXM] = 1'h1;
                `ASF_SEL_C: m[1][`ASF_ST1_C] = 1'h1;
                `ASF_SEL_CNF: m[1][`ASF_ST1_CNF] = 1'h1;
                `ASF_SEL_HM: m[1][`ASF_ST1_HM] = 1'h1;
                `ASF_SEL_XF: m[1][`ASF_ST1_XF] = 1'h1;
                default: m[6]--;
            endcase
        else
            m[6]--;
        // refused ops undo the step below
        m[6]++;
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        reset <= 0;
        @(posedge mclk);
        m = '{`ASF_ST0_RST, `ASF_ST1_RST, 0, 0, 0, 0, `ASF_PC_RST};
        for (int a = 0; a < 7; a++)
            rd(a[2:0]);
        void'($urandom(32'hf43b0afa));
        for (int i = 0; i < 24; i++)
        begin
            wr(1, `ASF_ST1_RST & ~({15'h0, i[0]} << `ASF_ST1_SXM));
            for (int a = 2; a < 6; a++)
                wr(a[2:0], 16'($urandom));
            op(ops[i % 3]);
            op(ops[(i / 3) % 3]);
            for (int a = 1; a < 7; a++)
                rd(a[2:0]);
        end
        wr(0, 0);
        wr(1, 0);
        foreach (sels[k])
        begin
            op({`ASF_OP_SET_CONTROL_BIT_OP_HI, sels[k]});
            rd(0);
            rd(1);
        end
        rd(6);
        rd(0);
        // let the last two reads come back before the verdict
        go(0, 0, 0, 0, 0);
        repeat (3) @(posedge mclk);
        if (q.size() != 0)
        begin
            error_cnt++;
            $display("wrong value read queue expected %0d seen %0d", 0, q.size());
        end
        summarize();
    end
endmodule // test_asf_unit
